// >>> verilog/ntps_pkg.sv
// Shared constants and types for the clock stamp path and its receiver
package ntps_pkg;
	// ----------------------------------------------------------------
	// Clocks and timing
	// ----------------------------------------------------------------
	localparam int          SYS_HZ     = 10_000_000;
	localparam int          STC_HZ     = 90_000;
	localparam int          TICK_GCD   = 10_000;
	localparam logic [9:0]  TICK_INC   = 10'(STC_HZ / TICK_GCD);
	localparam logic [9:0]  TICK_MOD   = 10'(SYS_HZ / TICK_GCD);
	localparam logic [16:0] TICK_MAX   = 17'(STC_HZ - 1);
	localparam int          FRAME_S    = 1;
	localparam int          FRAME_CYC  = FRAME_S * SYS_HZ;
	localparam int          JITTER_NS  = 500;
	// Ticks to 2^-32 s, scaled by 2^8; cycles to 2^-32 s, scaled by 2^16
	localparam logic [63:0] TICK_FRAC_K = ((64'd1 << 40) + 64'(STC_HZ / 2)) / 64'(STC_HZ);
	localparam logic [63:0] CYC_FRAC_K  = ((64'd1 << 48) + 64'(SYS_HZ / 2)) / 64'(SYS_HZ);
	localparam logic [16:0] TRIM_TICKS = 17'h0_0002;
	// ----------------------------------------------------------------
	// Timing packet and report fields
	// ----------------------------------------------------------------
	localparam logic [2:0]  NTP_VN      = 3'h4;
	localparam logic [2:0]  NTP_MODE    = 3'h5;
	localparam logic [7:0]  NTP_STRATUM = 8'h01;
	localparam logic [7:0]  NTP_POLL    = 8'h00;
	localparam logic [7:0]  NTP_PREC    = 8'hF0;
	localparam logic [31:0] NTP_REFID   = 32'h4750_5300;
	localparam logic [5:0]  NTP_LEN     = 6'h30;
	localparam logic [5:0]  NTP_REF_OFS = 6'h10;
	localparam logic [5:0]  NTP_TX_OFS  = 6'h28;
	localparam logic [7:0]  RTCP_VER    = 8'h80;
	localparam logic [7:0]  RTCP_SR     = 8'hC8;
	localparam logic [15:0] RTCP_WORDS  = 16'h0006;
	localparam logic [5:0]  RTCP_LEN    = 6'h1C;
	localparam logic [31:0] RTCP_SSRC   = 32'h1234_5678;	// Arbitrary value
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL = 8'h00;
	localparam logic [7:0]  REG_SEC  = 8'h04;
	localparam logic [7:0]  REG_TICK = 8'h08;
	localparam logic [7:0]  REG_NCNT = 8'h0C;
	localparam logic [7:0]  REG_HOLD = 8'h10;
	localparam int          CTRL_EN  = 0;
	localparam int          CTRL_LI  = 1;
	localparam logic [2:0]  CTRL_RST = 3'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_NTP  = 2'b01,
		ST_RTCP = 2'b10
	} ntps_st_t;
endpackage

// >>> verilog/ntps_link_if.sv
// Byte stream link between the stamp path and the receiving decoder
`timescale 1ns/10ps
interface ntps_link_if;
	logic       valid;
	logic       ready;
	logic [7:0] data;
	logic       sop;
	logic       eop;
	logic       frame;

	modport dev (output valid, output data, output sop, output eop, output frame, input ready);
	modport rcv (input valid, input data, input sop, input eop, input frame, output ready);
endinterface

// >>> verilog/ntps_stamp_tx.sv
// Transmit-side stamp path: 90 kHz clock, timing packet framer, APB registers
// What this block does
// - Version field carries the value 4
// - Mode field carries 5, broadcast mode
// - Stratum is 1 and stays untouched
// - Root delay and dispersion are zero
// - One timing packet per frame, poll one second
// - Precision reflects the 90 kHz clock
// - Reference stamp reloads on clock discontinuity
// - Receive stamp field is sent as zero
// - Transmit stamp holds the current system clock
// - Extension, key and MAC are omitted
// - System clock ticks at 90 kHz
// - Clock jitter stays below 500 ns
// - Holding delay is added to transmit stamp
// - 250 ms delay adds 1073741824 to fraction
// - Fraction overflow carries into the seconds
// - Packets never straddle a frame boundary
// - Each frame holds one timing and one report
// - Receiver loads clock from first stamp
// - Receiver trims clock on significant drift
// - Sender reports relate media stamp to clock
// - Exactly one timing stream per service
// - Decoder pulls unit one period early
`timescale 1ns/10ps
module ntps_stamp_tx
	import ntps_pkg::*;
#(
	parameter int FRAME_CYCLES = FRAME_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Link to the receiver
	ntps_link_if.dev         link
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic        ctrl_en;
	logic [1:0]  ctrl_li;
	logic [9:0]  tick_acc;
	logic [16:0] stc_tick;
	logic [31:0] stc_sec;
	logic [31:0] rtp_cnt;
	logic [63:0] ref_ts;
	logic [63:0] cap_ts;
	logic [63:0] tx_ts;
	logic [31:0] rtp_cap;
	logic [31:0] hold_cnt;
	logic [31:0] hold_last;
	logic        hold_run;
	logic [31:0] frame_cnt;
	logic [31:0] ntp_cnt;
	ntps_st_t    st;
	logic [5:0]  idx;
	logic        hit_q;

	logic        tick_now;
	logic        frame_start;
	logic        take;
	logic        last;
	logic        wr_acc;
	logic [63:0] stc_now;
	logic [40:0] frac_prod;
	logic [56:0] hold_prod;
	logic [383:0] ntp_img;
	logic [223:0] rtcp_img;
	logic [383:0] ntp_sh;
	logic [223:0] rtcp_sh;
	logic [7:0]  cur_byte;

	// ----------------------------------------------------------------
	// System time clock
	// ----------------------------------------------------------------
	// Phase accumulator gives 9 ticks per 1000 cycles; edge error is one
	// 100 ns cycle, well inside the jitter budget
	assign tick_now = (tick_acc + TICK_INC) >= TICK_MOD;
	assign wr_acc   = psel_i && penable_i && pwrite_i;
	assign frac_prod = 41'(41'(stc_tick) * TICK_FRAC_K[23:0]);
	assign stc_now  = {stc_sec, frac_prod[39:8]};

	// Tick generator and seconds counter; a seconds write restarts them
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_acc <= 10'h000;
			stc_tick <= 17'h0_0000;
			stc_sec  <= 32'h0000_0000;
			rtp_cnt  <= 32'h0000_0000;
		end else if (wr_acc && paddr_i == REG_SEC) begin
			tick_acc <= 10'h000;
			stc_tick <= 17'h0_0000;
			stc_sec  <= pwdata_i;
		end else if (tick_now) begin
			tick_acc <= tick_acc + TICK_INC - TICK_MOD;
			rtp_cnt  <= rtp_cnt + 32'h0000_0001;
			if (stc_tick == TICK_MAX) begin
				stc_tick <= 17'h0_0000;
				stc_sec  <= stc_sec + 32'h0000_0001;
			end else begin
				stc_tick <= stc_tick + 17'h0_0001;
			end
		end else begin
			tick_acc <= tick_acc + TICK_INC;
		end
	end

	// Reference stamp follows every discontinuity of the clock
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_ts <= 64'h0000_0000_0000_0000;
		end else if (wr_acc && paddr_i == REG_SEC) begin
			ref_ts <= {pwdata_i, 32'h0000_0000};
		end
	end

	// ----------------------------------------------------------------
	// Frame timer
	// ----------------------------------------------------------------
	// The boundary waits while a packet is still in flight, so packets
	// are moved rather than split
	assign frame_start = (frame_cnt == 32'(FRAME_CYCLES - 1)) && st == ST_IDLE
		&& !link.valid;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_cnt  <= 32'h0000_0000;
			link.frame <= 1'b0;
		end else begin
			// No marker while disabled, so empty frames are never reported
			link.frame <= frame_start && ctrl_en;
			if (frame_start) begin
				frame_cnt <= 32'h0000_0000;
			end else if (frame_cnt != 32'(FRAME_CYCLES - 1)) begin
				frame_cnt <= frame_cnt + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Stamp capture and holding delay
	// ----------------------------------------------------------------
	// Cycles are scaled to 2^-32 s; 2.5e6 cycles give 2^30 within a few
	// units, far under one tick
	assign hold_prod = 57'(57'(hold_cnt) * CYC_FRAC_K[24:0]);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_ts    <= 64'h0000_0000_0000_0000;
			tx_ts     <= 64'h0000_0000_0000_0000;
			rtp_cap   <= 32'h0000_0000;
			hold_cnt  <= 32'h0000_0000;
			hold_last <= 32'h0000_0000;
			hold_run  <= 1'b0;
		end else if (frame_start && ctrl_en) begin
			cap_ts   <= stc_now;
			rtp_cap  <= rtp_cnt;
			hold_cnt <= 32'h0000_0000;
			hold_run <= 1'b1;
		end else if (hold_run && link.valid && link.ready && link.sop) begin
			// Full 64-bit add: a fraction overflow carries into seconds
			tx_ts     <= cap_ts + 64'(hold_prod[56:16]);
			hold_last <= hold_cnt;
			hold_run  <= 1'b0;
		end else if (hold_run) begin
			hold_cnt <= hold_cnt + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Packet images
	// ----------------------------------------------------------------
	// No extension fields, key or MAC follow the 48 bytes
	assign ntp_img = {ctrl_li, NTP_VN, NTP_MODE,
		NTP_STRATUM,
		NTP_POLL,
		NTP_PREC,
		64'h0000_0000_0000_0000,
		NTP_REFID, ref_ts,
		64'h0000_0000_0000_0000,
		64'h0000_0000_0000_0000,
		tx_ts};
	assign rtcp_img = {RTCP_VER, RTCP_SR, RTCP_WORDS, RTCP_SSRC,
		cap_ts, rtp_cap, 64'h0000_0000_0000_0000};
	assign ntp_sh   = ntp_img << {idx, 3'b000};
	assign rtcp_sh  = rtcp_img << {idx, 3'b000};
	assign cur_byte = (st == ST_NTP) ? ntp_sh[383:376] : rtcp_sh[223:216];
	assign last     = (st == ST_NTP) ? (idx == NTP_LEN - 6'h01) : (idx == RTCP_LEN - 6'h01);
	assign take     = !link.valid || link.ready;

	// ----------------------------------------------------------------
	// Framer: one timing packet then one report after each boundary
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st  <= ST_IDLE;
			idx <= 6'h00;
		end else if (frame_start) begin
			st  <= ctrl_en ? ST_NTP : ST_IDLE;
			idx <= 6'h00;
		end else if (take && st != ST_IDLE) begin
			idx <= last ? 6'h00 : idx + 6'h01;
			if (last) begin
				case (st)
					ST_NTP:  st <= ST_RTCP;
					default: st <= ST_IDLE;
				endcase
			end
		end
	end

	// Output register stage; stalls while the receiver holds ready low
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link.valid <= 1'b0;
			link.data  <= 8'h00;
			link.sop   <= 1'b0;
			link.eop   <= 1'b0;
		end else if (take) begin
			link.valid <= st != ST_IDLE && !frame_start;
			link.data  <= cur_byte;
			link.sop   <= idx == 6'h00;
			link.eop   <= last;
		end
	end

	// Count of timing packets fully handed over
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ntp_cnt <= 32'h0000_0000;
		end else if (link.valid && link.ready && link.eop && st == ST_RTCP && idx == 6'h00) begin
			ntp_cnt <= ntp_cnt + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// APB registers
	// ----------------------------------------------------------------
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !hit_q;

	// Control bits take effect on the access cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_en <= CTRL_RST[CTRL_EN];
			ctrl_li <= CTRL_RST[CTRL_LI +: 2];
		end else if (wr_acc && paddr_i == REG_CTRL) begin
			ctrl_en <= pwdata_i[CTRL_EN];
			ctrl_li <= pwdata_i[CTRL_LI +: 2];
		end
	end

	// Read data is latched in the setup cycle so it comes from a flop
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
			hit_q    <= 1'b0;
		end else if (psel_i && !penable_i) begin
			hit_q <= 1'b1;
			case (paddr_i)
				REG_CTRL: prdata_o <= {29'h0000_0000, ctrl_li, ctrl_en};
				REG_SEC:  prdata_o <= stc_sec;
				REG_TICK: prdata_o <= {15'h0000, stc_tick};
				REG_NCNT: prdata_o <= ntp_cnt;
				REG_HOLD: prdata_o <= hold_last;
				default: begin
					prdata_o <= 32'h0000_0000;
					hit_q    <= 1'b0;
				end
			endcase
		end
	end
endmodule

// >>> verilog/ntps_stamp_rx.sv
// Receiving decoder end: packet parser and recovered 90 kHz system clock
`timescale 1ns/10ps
module ntps_stamp_rx
	import ntps_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// Link from the stamp path
	ntps_link_if.rcv         link,
	// User side
	input  wire logic        rx_ready_i,
	input  wire logic        pu_valid_i,
	input  wire logic [31:0] pu_pts_i,
	input  wire logic [31:0] pu_period_i,
	output logic      [31:0] stc_sec_o,
	output logic      [16:0] stc_tick_o,
	output logic             locked_o,
	output logic             ref_chg_o,
	output logic             trim_o,
	output logic      [15:0] rtcp_cnt_o,
	output logic             frame_bad_o,
	output logic             pu_pull_o
);
	// ----------------------------------------------------------------
	// Parser
	// ----------------------------------------------------------------
	logic [5:0]  idx;
	logic [5:0]  bn;
	logic        acc;
	logic        is_ntp;
	logic        is_rtcp;
	logic [63:0] ref_sh;
	logic [63:0] tx_sh;
	logic [63:0] ref_q;
	logic        ntp_done;
	logic        got_ntp;
	logic        got_rtcp;
	logic        seen_frame;
	logic [9:0]  tick_acc;
	logic [48:0] rx_prod;
	logic [16:0] rx_tick;
	logic [16:0] tdiff;
	logic        load;
	logic [31:0] rtp_now;

	assign link.ready = rx_ready_i;
	assign acc = link.valid && link.ready;
	assign bn  = link.sop ? 6'h00 : idx;

	// Bytes past the fixed fields, such as extensions, are skipped
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx      <= 6'h00;
			is_ntp   <= 1'b0;
			is_rtcp  <= 1'b0;
			ref_sh   <= 64'h0000_0000_0000_0000;
			tx_sh    <= 64'h0000_0000_0000_0000;
			ntp_done <= 1'b0;
		end else begin
			ntp_done <= 1'b0;
			if (acc) begin
				idx <= (bn == 6'h3F) ? bn : bn + 6'h01;
				if (link.sop) begin
					is_ntp  <= link.data[5:3] == NTP_VN && link.data[2:0] == NTP_MODE;
					is_rtcp <= link.data == RTCP_VER;
				end
				if (is_ntp && bn >= NTP_REF_OFS && bn < NTP_REF_OFS + 6'h08) begin
					ref_sh <= {ref_sh[55:0], link.data};
				end
				if (is_ntp && bn >= NTP_TX_OFS && bn < NTP_TX_OFS + 6'h08) begin
					tx_sh <= {tx_sh[55:0], link.data};
				end
				ntp_done <= link.eop && is_ntp && bn >= NTP_LEN - 6'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame content check: one timing packet and one report per frame
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			got_ntp     <= 1'b0;
			got_rtcp    <= 1'b0;
			seen_frame  <= 1'b0;
			frame_bad_o <= 1'b0;
			rtcp_cnt_o  <= 16'h0000;
		end else if (link.frame) begin
			seen_frame  <= 1'b1;
			frame_bad_o <= seen_frame && !(got_ntp && got_rtcp);
			got_ntp     <= 1'b0;
			got_rtcp    <= 1'b0;
		end else begin
			if (ntp_done) begin
				got_ntp <= 1'b1;
			end
			if (acc && link.eop && is_rtcp && bn >= RTCP_LEN - 6'h01) begin
				got_rtcp   <= 1'b1;
				rtcp_cnt_o <= rtcp_cnt_o + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Recovered system clock
	// ----------------------------------------------------------------
	assign rx_prod = 49'(49'(tx_sh[31:0]) * 49'(STC_HZ));
	assign rx_tick = rx_prod[48:32];
	assign tdiff   = (stc_tick_o > rx_tick) ? stc_tick_o - rx_tick : rx_tick - stc_tick_o;
	// First stamp, a new reference, or a drift beyond the trim window
	assign load = ntp_done && (!locked_o || ref_sh != ref_q
		|| stc_sec_o != tx_sh[63:32] || tdiff > TRIM_TICKS);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_acc   <= 10'h000;
			stc_tick_o <= 17'h0_0000;
			stc_sec_o  <= 32'h0000_0000;
		end else if (load) begin
			tick_acc   <= 10'h000;
			stc_tick_o <= rx_tick;
			stc_sec_o  <= tx_sh[63:32];
		end else if ((tick_acc + TICK_INC) >= TICK_MOD) begin
			tick_acc <= tick_acc + TICK_INC - TICK_MOD;
			if (stc_tick_o == TICK_MAX) begin
				stc_tick_o <= 17'h0_0000;
				stc_sec_o  <= stc_sec_o + 32'h0000_0001;
			end else begin
				stc_tick_o <= stc_tick_o + 17'h0_0001;
			end
		end else begin
			tick_acc <= tick_acc + TICK_INC;
		end
	end

	// Lock, reference tracking and event pulses
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			locked_o  <= 1'b0;
			ref_q     <= 64'h0000_0000_0000_0000;
			ref_chg_o <= 1'b0;
			trim_o    <= 1'b0;
		end else begin
			ref_chg_o <= ntp_done && locked_o && ref_sh != ref_q;
			trim_o    <= load && locked_o;
			if (ntp_done) begin
				locked_o <= 1'b1;
				ref_q    <= ref_sh;
			end
		end
	end

	// ----------------------------------------------------------------
	// Presentation unit release, one unit period ahead of its stamp
	// ----------------------------------------------------------------
	assign rtp_now = 32'(stc_sec_o * STC_HZ) + 32'(stc_tick_o);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pu_pull_o <= 1'b0;
		end else begin
			pu_pull_o <= pu_valid_i && locked_o && (rtp_now + pu_period_i >= pu_pts_i);
		end
	end
endmodule

// >>> verification/ntps_link_asserts.sv
// Protocol checker for the timing packet link between the two ends
`timescale 1ns/10ps
module ntps_link_asserts
	import ntps_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	// Link signals
	input  wire logic       valid,
	input  wire logic       ready,
	input  wire logic [7:0] data,
	input  wire logic       sop,
	input  wire logic       eop,
	input  wire logic       frame
);
	// ----------------------------------------------------------------
	// Byte position tracking
	// ----------------------------------------------------------------
	logic [5:0] idx;
	logic [1:0] nth;
	logic       infr;
	wire        xfer = valid && ready;

	// Byte index in packet and packet number in frame
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx <= 6'h00;
			nth <= 2'h0;
		end else if (frame) begin
			nth <= 2'h0;
			idx <= xfer ? 6'h01 : 6'h00;
		end else if (xfer) begin
			idx <= eop ? 6'h00 : idx + 6'h01;
			nth <= eop ? nth + 2'h1 : nth;
		end
	end

	// Frame stays open until its report is complete
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			infr <= 1'b0;
		end else if (frame) begin
			infr <= 1'b1;
		end else if (xfer && eop && nth == 2'h1) begin
			infr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_ntp_end;
		xfer && eop && nth == 2'h0;
	endsequence
	sequence s_rep_start;
		valid && sop && data == RTCP_VER;
	endsequence

	a_frame_one_cycle: assert property (frame |=> !frame)
		else $error("frame marker longer than one cycle");
	a_first_byte: assert property (frame |=> valid && sop && data[5:0] == {NTP_VN, NTP_MODE})
		else $error("bad first timing byte");
	a_stall_hold: assert property (valid && !ready |=> valid && $stable(data) && $stable(sop) && $stable(eop))
		else $error("byte changed while stalled");
	a_stratum_one: assert property (valid && nth == 2'h0 && idx == 6'h01 |-> data == NTP_STRATUM)
		else $error("stratum byte wrong");
	a_poll_prec: assert property (valid && nth == 2'h0 && idx[5:1] == 5'h01 |-> data == (idx[0] ? NTP_PREC : NTP_POLL))
		else $error("poll or precision byte wrong");
	a_root_zero: assert property (valid && nth == 2'h0 && idx >= 6'h04 && idx <= 6'h0B |-> data == 8'h00)
		else $error("root delay or dispersion not zero");
	a_rxstamp_zero: assert property (valid && nth == 2'h0 && idx >= 6'h20 && idx <= 6'h27 |-> data == 8'h00)
		else $error("receive stamp not zero");
	a_ntp_length: assert property (valid && nth == 2'h0 && eop |-> idx == 6'h2F)
		else $error("timing packet length wrong");
	a_report_next: assert property (s_ntp_end |=> s_rep_start)
		else $error("report does not follow timing packet");
	a_report_len: assert property (valid && nth == 2'h1 && eop |-> idx == 6'h1B)
		else $error("report length wrong");
	a_no_straddle: assert property (frame |-> !infr)
		else $error("frame started before report completed");
endmodule

// >>> verification/tb.sv
// Self-checking bench: stamp path and receiver joined back to back
`timescale 1ns/10ps
module tb
	import ntps_pkg::*;
;
	localparam int FC  = 400;
	localparam int TMO = 20000;
	localparam int TOL = 49000;	// One 90 kHz tick in 2^-32 s plus margin

	logic        sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, pu_pts_i, pu_period_i, stc_sec_o;
	logic        pready_o, pslverr_o, rx_ready_i, pu_valid_i;
	logic [16:0] stc_tick_o;
	logic        locked_o, ref_chg_o, trim_o, frame_bad_o, pu_pull_o;
	logic [15:0] rtcp_cnt_o;
	logic [7:0]  pk [0:47];
	logic [7:0]  ntp [0:47];
	logic [31:0] rd_v, s, s2;
	logic [63:0] a, d;
	logic        err_v;
	logic [1:0]  li;
	int          seed, k, bi, ntp_n, rep_n, ref_n, trim_n, cyc, failures, check_count;

	ntps_link_if ntps_link_if_inst ();
	ntps_stamp_tx #(.FRAME_CYCLES(FC)) ntps_stamp_tx_inst (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .link(ntps_link_if_inst));
	ntps_stamp_rx ntps_stamp_rx_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.link(ntps_link_if_inst), .rx_ready_i(rx_ready_i), .pu_valid_i(pu_valid_i),
		.pu_pts_i(pu_pts_i), .pu_period_i(pu_period_i), .stc_sec_o(stc_sec_o),
		.stc_tick_o(stc_tick_o), .locked_o(locked_o), .ref_chg_o(ref_chg_o), .trim_o(trim_o),
		.rtcp_cnt_o(rtcp_cnt_o), .frame_bad_o(frame_bad_o), .pu_pull_o(pu_pull_o));
	ntps_link_asserts ntps_link_asserts_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.valid(ntps_link_if_inst.valid), .ready(ntps_link_if_inst.ready),
		.data(ntps_link_if_inst.data), .sop(ntps_link_if_inst.sop),
		.eop(ntps_link_if_inst.eop), .frame(ntps_link_if_inst.frame));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One APB transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge sys_clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= ad;
		pwdata_i  <= wd;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do @(posedge sys_clk_i); while (pready_o !== 1'b1);
		rd_v = prdata_o;
		err_v = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Bounded only by the run timeout
	task automatic wait_ntp(input int n);
		while (ntp_n < n) @(posedge sys_clk_i);
		repeat (3) @(posedge sys_clk_i);
	endtask

	function automatic logic [31:0] fld(input int o);
		return {ntp[o], ntp[o+1], ntp[o+2], ntp[o+3]};
	endfunction

	// Holding delay in 2^-32 s units, carry into seconds included
	function automatic logic [63:0] exp_delta(input int c);
		return (64'(c) << 32) / 64'(SYS_HZ);
	endfunction

	// Tick of a 2^-32 s fraction on the 90 kHz clock
	function automatic logic [16:0] exp_tick(input logic [31:0] f);
		return 17'((64'(f) * 64'(STC_HZ)) >> 32);
	endfunction

	// Clock and hang guard
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == TMO) begin
			failures++;
			close_out();
		end
	end

	// Packet capture; reports are told apart by their first byte
	always @(posedge sys_clk_i) begin
		if (ref_chg_o === 1'b1) ref_n++;
		if (trim_o === 1'b1) trim_n++;
		if (ntps_link_if_inst.valid && ntps_link_if_inst.ready) begin
			if (ntps_link_if_inst.sop) bi = 0;
			if (bi < 48) pk[bi] = ntps_link_if_inst.data;
			bi++;
			if (ntps_link_if_inst.eop) begin
				if (pk[0] === RTCP_VER) rep_n++;
				else begin
					ntp = pk;
					ntp_n++;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 72;
		{rst_n_i, psel_i, penable_i, pwrite_i, pu_valid_i} = 5'h00;
		{paddr_i, pwdata_i, pu_pts_i, pu_period_i} = '0;
		rx_ready_i = 1'b1;
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		apb(1'b0, REG_NCNT, 32'h0000_0000);
		chk(rd_v, 64'h0);
		apb(1'b0, 8'hFC, 32'h0000_0000);
		chk({err_v, rd_v}, 64'h1_0000_0000);
		s = 32'($random(seed)) & 32'h0000_03FF;
		li = 2'($random(seed));
		apb(1'b1, REG_SEC, s);
		apb(1'b0, REG_SEC, 32'h0000_0000);
		chk(rd_v, s);
		apb(1'b0, REG_TICK, 32'h0000_0000);
		chk(rd_v, 64'h0);
		apb(1'b1, REG_CTRL, {29'h000_0000, li, 1'b1});
		apb(1'b0, REG_CTRL, 32'h0000_0000);
		chk(rd_v, {29'h000_0000, li, 1'b1});
		wait_ntp(1);
		chk(ntp[0], {li, NTP_VN, NTP_MODE});
		chk(ntp[1], NTP_STRATUM);
		chk({fld(16), fld(20)}, {s, 32'h0000_0000});
		chk({fld(32), fld(36)}, 64'h0);
		chk(fld(40), s);
		chk({locked_o, stc_sec_o}, {1'b1, s});
		a = {fld(40), fld(44)};
		// Stall the first byte of the next frame for a random count
		while (rep_n < 1) @(posedge sys_clk_i);
		rx_ready_i <= 1'b0;
		do @(posedge sys_clk_i); while (ntps_link_if_inst.frame !== 1'b1);
		k = 5 + (32'($random(seed)) & 15);
		repeat (k) @(posedge sys_clk_i);
		rx_ready_i <= 1'b1;
		wait_ntp(2);
		d = {fld(40), fld(44)} - a - exp_delta(FC + k);
		chk((d + 64'(TOL)) <= 64'(2 * TOL), 64'h1);
		apb(1'b0, REG_HOLD, 32'h0000_0000);
		chk(rd_v >= k && rd_v <= k + 3, 64'h1);
		// Clock discontinuity
		s2 = s + 5 + (32'($random(seed)) & 7);
		apb(1'b1, REG_SEC, s2);
		wait_ntp(ntp_n + 1);
		chk(fld(16), s2);
		chk(64'(ref_n), 64'h1);
		chk(stc_sec_o, s2);
		chk(trim_n >= 1, 1'b1);
		chk(17'(stc_tick_o - exp_tick(fld(44))) <= 17'h0_0001, 1'b1);
		// Presentation unit pull
		pu_valid_i  <= 1'b1;
		pu_period_i <= 32'h0000_0001;
		pu_pts_i    <= 32'h0000_0000;
		repeat (3) @(posedge sys_clk_i);
		chk(pu_pull_o, 1'b1);
		pu_pts_i <= 32'hFFFF_FF00;
		repeat (3) @(posedge sys_clk_i);
		chk(pu_pull_o, 1'b0);
		while (rep_n < ntp_n) @(posedge sys_clk_i);
		apb(1'b0, REG_NCNT, 32'h0000_0000);
		chk(rd_v, 64'(ntp_n));
		chk(rtcp_cnt_o, 64'(rep_n));
		chk({pk[0], pk[1], pk[2], pk[3], pk[8], pk[9], pk[10], pk[11]},
			{RTCP_VER, RTCP_SR, RTCP_WORDS, s2});
		chk(frame_bad_o, 1'b0);
		close_out();
	end
endmodule
